// *** rtl/rts_sequencer.v ***
// Power-up, oscillator start-up and reset-flag sequencer with Avalon-MM registers
//
// Overview of operation
// - After power-on pulse, run power-up delay, then oscillator start-up delay.
// - Total delay chosen from oscillator mode and power-up delay enable.
// - External clock mode with power-up delay disabled gives no delay.
// - Two-speed or fail-safe lets code run from internal oscillator during start-up.
// - Delays run from power-on pulse; master clear released late starts immediately.
// - Crystal modes: power-up period plus 1024 periods, or 1024; sleep wake 1024.
// - Power control register holds two flags telling the last reset kind.
// - Brown-out flag undefined after power-on; cleared by brown-out reset once set.
// - With brown-out field 00 the brown-out flag has no meaning.
// - Power-on flag cleared by power-on reset, kept through other resets.
// - Software writes one to power-on flag; device keeps it until next power-on.
//
// The Avalon-MM register port was left to the implementer.
`include "rts_map.vh"
module rts_sequencer #(
   parameter POWER_UP_DELAY_TIMER_CYCLES = `RTS_POWER_UP_DELAY_TIMER_CYCLES
) (
   input  wire        clk_sys,
   input  wire        resetn,
   input  wire        power_on_pulse,
   input  wire        brownout_pulse,
   input  wire        sleep_wake,
   input  wire        master_clear_pin_n,
   input  wire        osc_tick,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   output reg         avs_response_err,
   output reg         core_reset,
   output reg         fetch_enable,
   output reg         run_internal_osc,
   output reg         irq
);

// ----------------------------------------------------------------------
// States
// ----------------------------------------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_POWER_UP_DELAY_TIMER = 2'h1;
localparam ST_OST  = 2'h2;
localparam ST_DONE = 2'h3;

// ----------------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------------
reg  [4:0] sync1;
reg  [4:0] sync2;
reg  [4:0] sync_d;
wire [4:0] async_in;
assign async_in = {osc_tick, master_clear_pin_n, sleep_wake, brownout_pulse, power_on_pulse};

genvar gi;
generate
   for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys or negedge resetn) begin
         if (!resetn) begin
            sync1[gi]  <= 1'b0;
            sync2[gi]  <= 1'b0;
            sync_d[gi] <= 1'b0;
         end else begin
            sync1[gi]  <= async_in[gi];
            sync2[gi]  <= sync1[gi];
            sync_d[gi] <= sync2[gi];
         end
      end
   end
endgenerate

wire por_level  = sync2[0];
wire por_fall   = sync_d[0] & ~sync2[0];
wire bor_rise   = sync2[1] & ~sync_d[1];
wire wake_rise  = sync2[2] & ~sync_d[2];
wire master_clear_pin_high  = sync2[3];
wire tick_rise  = sync2[4] & ~sync_d[4];

// ----------------------------------------------------------------------
// Register decode
// ----------------------------------------------------------------------
function is_addr;
   input [7:0] a;
   input [7:0] ref_a;
   begin
      is_addr = (a == ref_a);
   end
endfunction

reg  [7:0]  config_reg;
reg         poweron_flag;
reg         brownout_flag;
reg  [2:0]  irq_status;
reg  [2:0]  irq_enable;
reg  [1:0]  state;
reg  [31:0] count;
reg         ost_phase_wake;

wire wr_acc   = avs_write & avs_waitrequest;
wire rd_acc   = avs_read & avs_waitrequest;
wire be0      = avs_byteenable[0];
wire wr_power_control_flags  = wr_acc & be0 & is_addr(avs_address, `RTS_ADDR_POWER_CONTROL_FLAGS);
wire wr_cfg   = wr_acc & be0 & is_addr(avs_address, `RTS_ADDR_CONFIG);
wire wr_ien   = wr_acc & be0 & is_addr(avs_address, `RTS_ADDR_IRQ_ENABLE);
wire wr_iclr  = wr_acc & be0 & is_addr(avs_address, `RTS_ADDR_IRQ_CLEAR);
wire mapped   = is_addr(avs_address, `RTS_ADDR_POWER_CONTROL_FLAGS) |
                is_addr(avs_address, `RTS_ADDR_CONFIG) |
                is_addr(avs_address, `RTS_ADDR_STATUS) |
                is_addr(avs_address, `RTS_ADDR_IRQ_STATUS) |
                is_addr(avs_address, `RTS_ADDR_IRQ_ENABLE) |
                is_addr(avs_address, `RTS_ADDR_IRQ_CLEAR);

wire [2:0] osc_mode = config_reg[`RTS_CFG_OSC_MSB:`RTS_CFG_OSC_LSB];
wire       power_up_delay_timer_en  = config_reg[`RTS_CFG_POWER_UP_DELAY_TIMER_EN_BIT];
wire       ost_mode = (osc_mode == `RTS_OSC_LP) | (osc_mode == `RTS_OSC_XT) |
                      (osc_mode == `RTS_OSC_HS);
wire       early_run = config_reg[`RTS_CFG_TWO_SPEED_BIT] | config_reg[`RTS_CFG_FAILSAFE_BIT];
wire       brownout_enable_field_on  = config_reg[`RTS_CFG_BROWNOUT_ENABLE_FIELD_MSB:`RTS_CFG_BROWNOUT_ENABLE_FIELD_LSB] != `RTS_BROWNOUT_ENABLE_FIELD_OFF;

// ----------------------------------------------------------------------
// Time-out sequencer
// ----------------------------------------------------------------------
reg  [1:0]  next_state;
reg  [31:0] next_count;
reg         seq_done_evt;

always @* begin
   next_state   = state;
   next_count   = count;
   seq_done_evt = 1'b0;
   case (state)
      ST_IDLE: begin
         if (por_fall || bor_rise) begin
            next_count = 32'h0;
            if (power_up_delay_timer_en) begin
               next_state = ST_POWER_UP_DELAY_TIMER;
            end else if (ost_mode) begin
               next_state = ST_OST;
            end else begin
               next_state = ST_DONE;
               seq_done_evt = 1'b1;
            end
         end else if (wake_rise && ost_mode) begin
            next_count = 32'h0;
            next_state = ST_OST;
         end
      end
      ST_POWER_UP_DELAY_TIMER: begin
         if (count >= POWER_UP_DELAY_TIMER_CYCLES - 1) begin
            next_count = 32'h0;
            if (ost_mode) begin
               next_state = ST_OST;
            end else begin
               next_state = ST_DONE;
               seq_done_evt = 1'b1;
            end
         end else begin
            next_count = count + 32'h1;
         end
      end
      ST_OST: begin
         if (tick_rise) begin
            if (count >= `RTS_OST_PERIODS - 1) begin
               next_count = 32'h0;
               next_state = ST_DONE;
               seq_done_evt = 1'b1;
            end else begin
               next_count = count + 32'h1;
            end
         end
      end
      ST_DONE: begin
         if (wake_rise && ost_mode) begin
            next_count = 32'h0;
            next_state = ST_OST;
         end
      end
      default: begin
         next_state = ST_IDLE;
         next_count = 32'h0;
      end
   endcase
   // Brown-out restarts the whole time-out from any state
   if (bor_rise) begin
      next_count   = 32'h0;
      seq_done_evt = 1'b0;
      if (power_up_delay_timer_en) begin
         next_state = ST_POWER_UP_DELAY_TIMER;
      end else if (ost_mode) begin
         next_state = ST_OST;
      end else begin
         next_state   = ST_DONE;
         seq_done_evt = 1'b1;
      end
   end
   if (por_level) begin
      next_state = ST_IDLE;
      next_count = 32'h0;
      seq_done_evt = 1'b0;
   end
end

always @(posedge clk_sys or negedge resetn) begin
   if (!resetn) begin
      state          <= ST_IDLE;
      count          <= 32'h0;
      ost_phase_wake <= 1'b0;
   end else begin
      state <= next_state;
      count <= next_count;
      if (next_state == ST_OST && (state != ST_OST || bor_rise)) begin
         ost_phase_wake <= (state == ST_IDLE || state == ST_DONE) & wake_rise & ~bor_rise;
      end
   end
end

// ----------------------------------------------------------------------
// Reset outputs
// ----------------------------------------------------------------------
wire delays_done = (state == ST_DONE) | (state == ST_OST && ost_phase_wake);
wire ost_early   = (state == ST_OST) & early_run;
wire core_release = (delays_done | ost_early) & master_clear_pin_high;

always @(posedge clk_sys or negedge resetn) begin
   if (!resetn) begin
      core_reset       <= 1'b1;
      fetch_enable     <= 1'b0;
      run_internal_osc <= 1'b0;
   end else begin
      core_reset       <= ~core_release;
      fetch_enable     <= core_release & (state != ST_OST || ost_early || ost_phase_wake);
      run_internal_osc <= ost_early & master_clear_pin_high;
   end
end

// ----------------------------------------------------------------------
// Registers and interrupts
// ----------------------------------------------------------------------
wire [2:0] irq_evt;
assign irq_evt[`RTS_IRQ_SEQ_DONE_BIT] = seq_done_evt;
assign irq_evt[`RTS_IRQ_BROWNOUT_BIT] = bor_rise & brownout_enable_field_on;
assign irq_evt[`RTS_IRQ_POWERON_BIT]  = por_fall;

always @(posedge clk_sys or negedge resetn) begin
   if (!resetn) begin
      config_reg    <= `RTS_CONFIG_RESET;
      poweron_flag  <= 1'b0;
      brownout_flag <= 1'b0;
      irq_status    <= 3'h0;
      irq_enable    <= 3'h0;
   end else begin
      if (wr_cfg) begin
         config_reg <= avs_writedata[7:0];
      end
      if (wr_ien) begin
         irq_enable <= avs_writedata[2:0];
      end
      if (wr_power_control_flags) begin
         poweron_flag  <= avs_writedata[`RTS_POWER_CONTROL_FLAGS_POWERON_BIT];
         brownout_flag <= avs_writedata[`RTS_POWER_CONTROL_FLAGS_BROWNOUT_BIT];
      end
      if (por_level) begin
         poweron_flag <= 1'b0;
      end
      if (bor_rise && brownout_enable_field_on) begin
         brownout_flag <= 1'b0;
      end
      irq_status <= (irq_status & ~({3{wr_iclr}} & avs_writedata[2:0])) | irq_evt;
   end
end

always @(posedge clk_sys or negedge resetn) begin
   if (!resetn) begin
      avs_waitrequest  <= 1'b1;
      avs_readdata     <= 32'h0;
      avs_response_err <= 1'b0;
      irq              <= 1'b0;
   end else begin
      irq             <= |(irq_status & irq_enable);
      avs_waitrequest <= ~(rd_acc | wr_acc);
      if (rd_acc | wr_acc) begin
         avs_response_err <= ~mapped;
      end
      if (rd_acc) begin
         avs_readdata <= 32'h0;
         if (is_addr(avs_address, `RTS_ADDR_POWER_CONTROL_FLAGS)) begin
            avs_readdata[`RTS_POWER_CONTROL_FLAGS_POWERON_BIT]  <= poweron_flag;
            avs_readdata[`RTS_POWER_CONTROL_FLAGS_BROWNOUT_BIT] <= brownout_flag;
         end else if (is_addr(avs_address, `RTS_ADDR_CONFIG)) begin
            avs_readdata[7:0] <= config_reg;
         end else if (is_addr(avs_address, `RTS_ADDR_STATUS)) begin
            avs_readdata[3:0] <= {core_release, ost_early, state};
         end else if (is_addr(avs_address, `RTS_ADDR_IRQ_STATUS)) begin
            avs_readdata[2:0] <= irq_status;
         end else if (is_addr(avs_address, `RTS_ADDR_IRQ_ENABLE)) begin
            avs_readdata[2:0] <= irq_enable;
         end
      end
   end
end

endmodule

// *** rtl/rts_map.vh ***
// Register offsets, field positions, reset values and timing counts of the start-up sequencer
`ifndef RTS_MAP_VH
`define RTS_MAP_VH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RTS_ADDR_POWER_CONTROL_FLAGS 8'h8E
`define RTS_ADDR_CONFIG              8'h90
`define RTS_ADDR_STATUS              8'h94
`define RTS_ADDR_IRQ_STATUS          8'h98
`define RTS_ADDR_IRQ_ENABLE          8'h9C
`define RTS_ADDR_IRQ_CLEAR           8'hA0
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RTS_POWER_CONTROL_FLAGS_BROWNOUT_BIT   0
`define RTS_POWER_CONTROL_FLAGS_POWERON_BIT    1
`define RTS_CFG_OSC_LSB         0
`define RTS_CFG_OSC_MSB         2
`define RTS_CFG_POWER_UP_DELAY_TIMER_EN_BIT     3
`define RTS_CFG_TWO_SPEED_BIT   4
`define RTS_CFG_FAILSAFE_BIT    5
`define RTS_CFG_BROWNOUT_ENABLE_FIELD_LSB       6
`define RTS_CFG_BROWNOUT_ENABLE_FIELD_MSB       7
`define RTS_IRQ_SEQ_DONE_BIT    0
`define RTS_IRQ_BROWNOUT_BIT    1
`define RTS_IRQ_POWERON_BIT     2
// ----------------------------------------------------------------------
// Oscillator mode codes
// ----------------------------------------------------------------------
`define RTS_OSC_LP              3'h0
`define RTS_OSC_XT              3'h1
`define RTS_OSC_HS              3'h2
`define RTS_OSC_EC              3'h3
`define RTS_OSC_INTERNAL_OSCILLATOR          3'h4
`define RTS_OSC_RC              3'h5
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RTS_CONFIG_RESET        8'h0A
`define RTS_BROWNOUT_ENABLE_FIELD_OFF           2'h0
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RTS_OST_PERIODS         1024
`define RTS_POWER_UP_DELAY_TIMER_MS             64
`define RTS_CLK_HZ              50000000
`define RTS_POWER_UP_DELAY_TIMER_CYCLES         ((`RTS_CLK_HZ / 1000) * `RTS_POWER_UP_DELAY_TIMER_MS)
`endif

// *** verif/rts_sequencer_sva.sv ***
// Bus handshake and reset-release checker of the start-up sequencer
`include "rts_map.vh"
module rts_sequencer_chk #(
   parameter POWER_UP_DELAY_TIMER_CYCLES = 20
) (
   input logic        clk_sys,
   input logic        resetn,
   input logic        power_on_pulse,
   input logic        master_clear_pin_n,
   input logic [7:0]  avs_address,
   input logic        avs_read,
   input logic        avs_write,
   input logic [31:0] avs_readdata,
   input logic        avs_waitrequest,
   input logic        avs_response_err,
   input logic        core_reset,
   input logic        fetch_enable,
   input logic        run_internal_osc
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   wire mapped = avs_address == `RTS_ADDR_POWER_CONTROL_FLAGS || (avs_address[1:0] == 2'h0
                 && avs_address >= `RTS_ADDR_CONFIG && avs_address <= `RTS_ADDR_IRQ_CLEAR);
   sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_end; !avs_waitrequest ##1 avs_waitrequest; endsequence
   sequence s_por_held; power_on_pulse [*5]; endsequence
   property p_answer; s_req |=> s_end; endproperty
   property p_idle; !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest; endproperty
   property p_unmap; avs_read && !avs_waitrequest && !mapped |-> avs_readdata == 32'h0
      && avs_response_err; endproperty
   property p_map; avs_read && !avs_waitrequest && mapped |-> !avs_response_err; endproperty
   property p_rdhold; !avs_read |=> $stable(avs_readdata); endproperty
   property p_por; s_por_held |-> core_reset && !fetch_enable; endproperty
   property p_release; $fell(core_reset) |-> master_clear_pin_n && !power_on_pulse; endproperty
   property p_fetch; fetch_enable |-> !core_reset || run_internal_osc; endproperty
   a_answer: assert property (p_answer) else $error("no one-cycle answer");
   a_idle: assert property (p_idle) else $error("answer without request");
   a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
   a_map: assert property (p_map) else $error("error on mapped read");
   a_rdhold: assert property (p_rdhold) else $error("read data moved");
   a_por: assert property (p_por) else $error("core free during power-on");
   a_release: assert property (p_release) else $error("release with clear low");
   a_fetch: assert property (p_fetch) else $error("fetch while in reset");
endmodule
bind rts_sequencer rts_sequencer_chk #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_CYCLES)) u_chk (
   .clk_sys(clk_sys), .resetn(resetn), .power_on_pulse(power_on_pulse),
   .master_clear_pin_n(master_clear_pin_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err),
   .core_reset(core_reset), .fetch_enable(fetch_enable), .run_internal_osc(run_internal_osc));

// *** verif/rts_sequencer_tb_top.sv ***
// Self-checking bench of the start-up sequencer
`include "rts_map.vh"
module rts_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam DLY = 20;
   localparam T = 8192;
   logic        clk_sys = 0, resetn = 0, power_on_pulse = 0, brownout_pulse = 0;
   logic        master_clear_pin_n = 1, osc_tick = 0, avs_read = 0, avs_write = 0;
   logic [7:0]  avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
   logic        avs_waitrequest, avs_response_err, core_reset, fetch_enable, run_internal_osc;
   logic        irq, sleep_wake = 0;
   logic [2:0]  osc_div = 3'h0;
   int          error_cnt = 0, checked = 0, n;
   always #10 clk_sys = ~clk_sys;
   // Oscillator period of eight system cycles
   always @(posedge clk_sys) begin
      osc_div <= osc_div + 3'h1;
      osc_tick <= osc_div[2];
   end
   rts_sequencer #(.POWER_UP_DELAY_TIMER_CYCLES(DLY)) u_rts_sequencer (
      .clk_sys(clk_sys), .resetn(resetn), .power_on_pulse(power_on_pulse),
      .brownout_pulse(brownout_pulse), .sleep_wake(sleep_wake),
      .master_clear_pin_n(master_clear_pin_n),
      .osc_tick(osc_tick), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response_err(avs_response_err), .core_reset(core_reset),
      .fetch_enable(fetch_enable), .run_internal_osc(run_internal_osc), .irq(irq));
   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task automatic stop_test;
      if (error_cnt == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int k;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      for (k = 0; k < 50; k++) begin
         @(posedge clk_sys);
         if (avs_waitrequest === 1'b0) break;
      end
      chk(k < 50, 1);
      d = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rel(input int lo, input int hi);
      for (n = 0; n < 20000 && core_reset !== 1'b0; n++)
         @(posedge clk_sys);
      chk(n >= lo && n <= hi, 1);
   endtask
   task automatic power_up(input logic [7:0] cfg, input int lo, input int hi, input logic hold);
      acc(1'b1, `RTS_ADDR_CONFIG, {24'h0, cfg});
      master_clear_pin_n <= !hold;
      power_on_pulse <= 1'b1;
      repeat (6) @(posedge clk_sys);
      power_on_pulse <= 1'b0;
      if (hold) begin
         repeat (100) @(posedge clk_sys);
         chk({31'h0, core_reset}, 1);
         master_clear_pin_n <= 1'b1;
      end
      rel(lo, hi);
   endtask
   // ----------------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      acc(1'b0, `RTS_ADDR_CONFIG, 32'h0);
      chk(d, {24'h0, `RTS_CONFIG_RESET});
      acc(1'b0, 8'hFC, 32'h0);
      chk(d, 32'h0);
      power_up(8'h08, DLY + T - 8, DLY + T + 40, 1'b0);
      power_up(8'h02, T - 8, T + 40, 1'b0);
      power_up(8'h09, DLY + T - 8, DLY + T + 40, 1'b0);
      // Wake from sleep in crystal mode runs only the oscillator start-up count
      sleep_wake <= 1'b1;
      repeat (16) @(posedge clk_sys);
      sleep_wake <= 1'b0;
      acc(1'b0, `RTS_ADDR_STATUS, 32'h0);
      chk(d & 32'h3, 32'h2);
      chk({31'h0, core_reset}, 0);
      repeat (T - 80) @(posedge clk_sys);
      acc(1'b0, `RTS_ADDR_STATUS, 32'h0);
      chk(d & 32'h3, 32'h2);
      repeat (80) @(posedge clk_sys);
      acc(1'b0, `RTS_ADDR_STATUS, 32'h0);
      chk(d & 32'h3, 32'h3);
      power_up(8'h03, 0, 12, 1'b0);
      power_up(8'h0B, DLY, DLY + 12, 1'b0);
      power_up(8'h04, 0, 12, 1'b0);
      power_up(8'h0D, DLY, DLY + 12, 1'b0);
      power_up(8'h11, 0, 12, 1'b0);
      repeat (4) @(posedge clk_sys);
      chk({31'h0, run_internal_osc}, 1);
      power_up(8'h21, 0, 12, 1'b0);
      repeat (4) @(posedge clk_sys);
      chk({31'h0, run_internal_osc}, 1);
      power_up(8'h0B, 0, 6, 1'b1);
      acc(1'b1, `RTS_ADDR_IRQ_ENABLE, 32'h1);
      acc(1'b1, `RTS_ADDR_IRQ_CLEAR, 32'h7);
      acc(1'b1, `RTS_ADDR_POWER_CONTROL_FLAGS, 32'h3);
      acc(1'b1, `RTS_ADDR_CONFIG, 32'h43);
      brownout_pulse <= 1'b1;
      repeat (4) @(posedge clk_sys);
      brownout_pulse <= 1'b0;
      rel(0, 12);
      acc(1'b0, `RTS_ADDR_POWER_CONTROL_FLAGS, 32'h0);
      chk(d, 32'h2);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 1);
      acc(1'b0, `RTS_ADDR_IRQ_STATUS, 32'h0);
      chk(d & 32'h1, 32'h1);
      acc(1'b1, `RTS_ADDR_IRQ_ENABLE, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 0);
      acc(1'b1, `RTS_ADDR_IRQ_ENABLE, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 1);
      acc(1'b1, `RTS_ADDR_IRQ_CLEAR, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 0);
      power_up(8'h03, 0, 12, 1'b0);
      acc(1'b0, `RTS_ADDR_POWER_CONTROL_FLAGS, 32'h0);
      chk(d & 32'h2, 32'h0);
      stop_test;
   end
   initial begin
      repeat (80000) @(posedge clk_sys);
      error_cnt++;
      stop_test;
   end
endmodule
